// ===== pfs_pin_fault_supervisor.v
// pfs_pin_fault_supervisor.v - fault supervisor that gates the low-side pulses and picks
// the restart response: a supply restart cycle or the long fault-recovery delay.
// assumes all comparator flags are synchronous to sys_clk_in and the supply logic
// reports turn-on and turn-off thresholds as levels.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_consts.vh"
module pfs_pin_fault_supervisor #(
   parameter [`PFS_TMR_W-1:0] RECOVERY_CYC = `PFS_RECOVERY_CYC,  // long delay count
   parameter [`PFS_TMR_W-1:0] LINE_CAP_CYC = `PFS_LINE_CAP_CYC   // discharge pin count
) (
   input  wire       sys_clk_in,            // system clock, 20 MHz
   input  wire       nrst_in,               // synchronous reset, active low
   input  wire       clk_en_in,             // freezes all state while low
   input  wire       supply_on_in,          // supply at turn-on threshold
   input  wire       supply_off_in,         // supply down at turn-off threshold
   input  wire       gate_req_in,           // pulse request from the control loop
   input  wire       over_temp_in,          // junction over-temperature flag
   input  wire       sense_over_ocp_in,     // sense above overcurrent_level
   input  wire       hv_reg_below_14v_in,   // hv_sense_regulator_pin below 14 V
   input  wire       hv_reg_over_15v_in,    // hv_sense_regulator_pin above 15 V
   input  wire       demag_pin_fault_in,    // demag_setting_pin open or short
   input  wire       zvd_pin_fault_in,      // zero_volt_delay_pin open or short
   input  wire       demag_above_th_in,     // demag resistor at or above threshold
   input  wire       device_type_sel_in,    // device-type select
   input  wire       line_cap_ov_in,        // line_cap_discharge_pin over threshold
   output wire       low_side_gate_pulse_out, // gate pulse, registered
   output wire       supply_cycle_out,      // supply_undervoltage_cycle in progress
   output wire       fault_recovery_out,    // fault_recovery_delay in progress
   output wire       switching_out,         // switching allowed
   output wire [3:0] fault_cause_out        // cause of the last restart
);

   // ****************************************
   // state
   // ****************************************
   localparam [4:0] ST_OFF     = `PFS_ST_OFF;
   localparam [4:0] ST_CHECK   = `PFS_ST_CHECK;
   localparam [4:0] ST_RUN     = `PFS_ST_RUN;
   localparam [4:0] ST_CYCLE   = `PFS_ST_CYCLE;
   localparam [4:0] ST_RECOVER = `PFS_ST_RECOVER;

   localparam [`PFS_TMR_W-1:0] CHECK_LIM = `PFS_CHECK_CYC;
   localparam [`PFS_TMR_W-1:0] LONG_LIM  = `PFS_LIMIT_LONG_CYC;
   localparam [`PFS_TMR_W-1:0] SHORT_LIM = `PFS_LIMIT_SHORT_CYC;

   reg  [4:0]            state_q;
   reg  [4:0]            state_d;
   reg  [3:0]            cause_q;
   reg  [3:0]            cause_d;
   reg                   gate_q;
   reg                   gate_d;
   reg                   first_q;
   reg                   first_d;
   reg  [`PFS_TMR_W-1:0] ontime_q;
   wire [`PFS_TMR_W-1:0] first_lim;
   wire                  in_run;
   wire                  first_hit;
   wire                  pulse_end;
   wire                  restart;
   wire                  check_done;
   wire                  line_cap_done;
   wire                  recover_done;
   wire [1:0]            trip;
   wire [1:0]            cond;
   wire                  prog_fault;

   assign in_run     = (state_q == ST_RUN);
   assign prog_fault = demag_pin_fault_in | zvd_pin_fault_in;

   // ****************************************
   // first pulse on-time limit
   // ****************************************
   // type select high always takes the long limit; otherwise the demag range decides
   assign first_lim = (device_type_sel_in || demag_above_th_in) ? LONG_LIM
                                                                : SHORT_LIM;
   // ontime_q is one short of the cycles the first pulse has been high, so the
   // cut lands after exactly first_lim high cycles, not one cycle later
   assign first_hit = first_q && gate_q && (ontime_q >= (first_lim - 1'b1));

   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         ontime_q <= {`PFS_TMR_W{1'b0}};
      end else if (clk_en_in) begin
         if (!first_q) begin
            ontime_q <= {`PFS_TMR_W{1'b0}};
         end else if (gate_q) begin
            ontime_q <= ontime_q + 1'b1;
         end
      end
   end

   // ****************************************
   // timers
   // ****************************************
   pfs_timer u_check_tmr (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .clk_en_in  (clk_en_in),
      .run_in     (state_q == ST_CHECK),
      .limit_in   (CHECK_LIM),
      .done_out   (check_done)
   );

   // the discharge pin must stay over its threshold without a break
   pfs_timer u_line_cap_tmr (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .clk_en_in  (clk_en_in),
      .run_in     (in_run && line_cap_ov_in),
      .limit_in   (LINE_CAP_CYC),
      .done_out   (line_cap_done)
   );

   pfs_timer u_recover_tmr (
      .sys_clk_in (sys_clk_in),
      .nrst_in    (nrst_in),
      .clk_en_in  (clk_en_in),
      .run_in     (state_q == ST_RECOVER),
      .limit_in   (RECOVERY_CYC),
      .done_out   (recover_done)
   );

   // ****************************************
   // consecutive pulse counters
   // ****************************************
   // index 0: sense pin open, index 1: regulator over-voltage
   assign cond      = {hv_reg_over_15v_in, sense_over_ocp_in};
   assign pulse_end = gate_q & ~gate_d;
   assign restart   = (state_q == ST_RUN) && (state_d != ST_RUN);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_cnt
         pfs_pulse_counter u_cnt (
            .sys_clk_in   (sys_clk_in),
            .nrst_in      (nrst_in),
            .clk_en_in    (clk_en_in),
            .clr_in       (restart || !in_run),
            .gate_in      (gate_q),
            .pulse_end_in (pulse_end),
            .cond_in      (cond[gi]),
            .trip_out     (trip[gi])
         );
      end
   endgenerate

   // ****************************************
   // next state
   // ****************************************
   always @* begin
      state_d = state_q;
      cause_d = cause_q;
      first_d = first_q;
      gate_d  = 1'b0;
      case (state_q)
         ST_OFF: begin
            if (supply_on_in) begin
               if (over_temp_in) begin
                  state_d = ST_CYCLE;
                  cause_d = `PFS_F_OVER_TEMP;
               end else if (prog_fault) begin
                  state_d = ST_CYCLE;
                  cause_d = `PFS_F_PROG_PIN;
               end else begin
                  state_d = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            if (over_temp_in) begin
               state_d = ST_CYCLE;
               cause_d = `PFS_F_OVER_TEMP;
            end else if (check_done) begin
               if (hv_reg_below_14v_in) begin
                  state_d = ST_CYCLE;
                  cause_d = `PFS_F_REG_LOW;
               end else begin
                  state_d = ST_RUN;
                  first_d = 1'b1;
               end
            end
         end
         ST_RUN: begin
            gate_d = gate_req_in & ~first_hit;
            if (first_q && gate_q && !gate_d) begin
               first_d = 1'b0;
            end
            // short and open sense faults take the long delay; the rest cycle the supply
            if (first_hit) begin
               state_d = ST_RECOVER;
               cause_d = `PFS_F_SENSE_SHORT;
            end else if (trip[0]) begin
               state_d = ST_RECOVER;
               cause_d = `PFS_F_SENSE_OPEN;
            end else if (over_temp_in) begin
               state_d = ST_CYCLE;
               cause_d = `PFS_F_OVER_TEMP;
            end else if (trip[1]) begin
               state_d = ST_CYCLE;
               cause_d = `PFS_F_REG_OVER;
            end else if (line_cap_done) begin
               state_d = ST_CYCLE;
               cause_d = `PFS_F_LINE_CAP;
            end else if (supply_off_in) begin
               state_d = ST_OFF;
            end
            if (state_d != ST_RUN) begin
               gate_d  = 1'b0;
               first_d = 1'b0;
            end
         end
         ST_CYCLE: begin
            // no latch-off: every fault path ends back at a normal start
            if (supply_off_in) begin
               state_d = ST_OFF;
            end
         end
         ST_RECOVER: begin
            if (recover_done && supply_off_in) begin
               state_d = ST_OFF;
            end
         end
         default: begin
            state_d = ST_OFF;
            first_d = 1'b0;
         end
      endcase
      if (!in_run) begin
         gate_d = 1'b0;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         state_q <= ST_OFF;
         cause_q <= `PFS_F_NONE;
         gate_q  <= 1'b0;
         first_q <= 1'b0;
      end else if (clk_en_in) begin
         state_q <= state_d;
         cause_q <= cause_d;
         gate_q  <= gate_d;
         first_q <= first_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign low_side_gate_pulse_out = gate_q;
   assign supply_cycle_out        = (state_q == ST_CYCLE) || (state_q == ST_RECOVER);
   assign fault_recovery_out      = (state_q == ST_RECOVER);
   assign switching_out           = in_run;
   assign fault_cause_out         = cause_q;

endmodule // pfs_pin_fault_supervisor
`default_nettype wire

// ===== pfs_consts.vh
// pfs_consts.vh - constants of the pin fault supervisor: states, fault codes, timing.
// assumes a 20 MHz system clock; every count is derived from its time and that rate.
//
// Notes on behaviour
// - over-temperature stops switching, runs supply restart
// - still hot after restart: restart again
// - all pin faults recover automatically, never latch
// - first pulse too long: cut, fault recovery
// - limit 2us when type high, else resistor-based
// - demag resistor above threshold selects longer limit
// - sense over level three pulses: fault recovery
// - regulator below 14V after 10us: restart
// - regulator over 15V three pulses: restart
// - programming pin faults at turn-on: restart
// - discharge pin over 750us: restart
// - recovery delay: no pulses, then wait turn-off
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// ****************************************
// clock and times
// ****************************************
`define PFS_CLK_MHZ          20
`define PFS_CHECK_NS         10000
`define PFS_LIMIT_LONG_NS    2000
`define PFS_LIMIT_SHORT_NS   1000
`define PFS_LINE_CAP_US      750
`define PFS_RECOVERY_US      1500000
// the times above counted at 20 MHz, sized to the timer width so no connection truncates
`define PFS_CHECK_CYC        25'h0_00c8
`define PFS_LIMIT_LONG_CYC   25'h0_0028
`define PFS_LIMIT_SHORT_CYC  25'h0_0014
`define PFS_LINE_CAP_CYC     25'h0_3a98
`define PFS_RECOVERY_CYC     25'h1c9_c380
`define PFS_TMR_W            25
`define PFS_PULSE_COUNT      2'h3

// ****************************************
// states, one-hot
// ****************************************
`define PFS_ST_OFF           5'h01
`define PFS_ST_CHECK         5'h02
`define PFS_ST_RUN           5'h04
`define PFS_ST_CYCLE         5'h08
`define PFS_ST_RECOVER       5'h10

// ****************************************
// fault cause codes
// ****************************************
`define PFS_F_NONE           4'h0
`define PFS_F_OVER_TEMP      4'h1
`define PFS_F_PROG_PIN       4'h2
`define PFS_F_REG_LOW        4'h3
`define PFS_F_REG_OVER       4'h4
`define PFS_F_LINE_CAP       4'h5
`define PFS_F_SENSE_SHORT    4'h6
`define PFS_F_SENSE_OPEN     4'h7

`endif

// ===== pfs_timer.v
// pfs_timer.v - up counter that saturates at a limit and flags it.
// assumes the caller holds run_in high for as long as the time should accumulate.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_consts.vh"
module pfs_timer (
   input  wire                  sys_clk_in,   // system clock
   input  wire                  nrst_in,      // synchronous reset, active low
   input  wire                  clk_en_in,    // freezes state while low
   input  wire                  run_in,       // count while high, clear while low
   input  wire [`PFS_TMR_W-1:0] limit_in,     // count that ends the time
   output wire                  done_out      // level: limit reached
);
   reg [`PFS_TMR_W-1:0] cnt_q;

   // saturating so done holds until run_in drops
   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         cnt_q <= {`PFS_TMR_W{1'b0}};
      end else if (clk_en_in) begin
         if (!run_in) begin
            cnt_q <= {`PFS_TMR_W{1'b0}};
         end else if (cnt_q < limit_in) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   assign done_out = run_in && (cnt_q >= limit_in);
endmodule // pfs_timer
`default_nettype wire

// ===== pfs_pulse_counter.v
// pfs_pulse_counter.v - counts consecutive gate pulses during which a condition was seen.
// assumes pulse_end_in is a one-cycle strobe at the last high cycle of each pulse.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_consts.vh"
module pfs_pulse_counter (
   input  wire sys_clk_in,    // system clock
   input  wire nrst_in,       // synchronous reset, active low
   input  wire clk_en_in,     // freezes state while low
   input  wire clr_in,        // restart begins: forget history
   input  wire gate_in,       // gate pulse level
   input  wire pulse_end_in,  // strobe: pulse ends this cycle
   input  wire cond_in,       // fault condition level
   output wire trip_out       // level: three consecutive pulses seen
);
   reg [1:0] cnt_q;
   reg       seen_q;
   wire      hit;

   // the condition counts if it showed at any cycle of the pulse
   assign hit = seen_q | (gate_in & cond_in);

   always @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         cnt_q  <= 2'h0;
         seen_q <= 1'b0;
      end else if (clk_en_in) begin
         if (clr_in) begin
            cnt_q  <= 2'h0;
            seen_q <= 1'b0;
         end else if (pulse_end_in) begin
            seen_q <= 1'b0;
            if (!hit) begin
               cnt_q <= 2'h0;
            end else if (cnt_q != `PFS_PULSE_COUNT) begin
               cnt_q <= cnt_q + 2'h1;
            end
         end else if (gate_in && cond_in) begin
            seen_q <= 1'b1;
         end
      end
   end

   assign trip_out = (cnt_q == `PFS_PULSE_COUNT);
endmodule // pfs_pulse_counter
`default_nettype wire

// ===== pfs_consts_unused_guard.v
`timescale 1ns/10ps

// ===== pfs_monitor.sv
// pfs_monitor.sv - port assertions for the pin fault supervisor.
// assumes clk_en_in is held high; the helper counters never freeze.
`timescale 1ns/10ps
`default_nettype none
module pfs_monitor #(
   parameter int RECOVERY_CYC = 100,  // long delay count
   parameter int LINE_CAP_CYC = 50    // discharge pin count
) (
   input wire logic       sys_clk_in,               // system clock
   input wire logic       nrst_in,                  // sync reset, active low
   input wire logic       over_temp_in,             // over-temperature flag
   input wire logic       hv_reg_below_14v_in,      // regulator pin low
   input wire logic       demag_above_th_in,        // demag resistor high
   input wire logic       device_type_sel_in,       // device-type select
   input wire logic       line_cap_ov_in,           // discharge pin high
   input wire logic       low_side_gate_pulse_out,  // gate pulse
   input wire logic       supply_cycle_out,         // restart in progress
   input wire logic       fault_recovery_out,       // long delay running
   input wire logic       switching_out,            // run state
   input wire logic [3:0] fault_cause_out           // last cause
);
   // ****************************************
   // helper counters and checks
   // ****************************************
   logic [7:0] hi_q;
   logic [7:0] lim;
   logic       first_q;
   int         rec_q;
   int         lc_q;
   assign lim = (device_type_sel_in | demag_above_th_in) ? 8'h28 : 8'h14;
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         hi_q    <= 8'h00;
         first_q <= 1'b1;
         rec_q   <= 0;
         lc_q    <= 0;
      end else begin
         hi_q    <= low_side_gate_pulse_out ? hi_q + 8'h01 : 8'h00;
         // armed until the first pulse after entering run has ended
         first_q <= !switching_out || (first_q && (low_side_gate_pulse_out || hi_q == 8'h00));
         rec_q   <= fault_recovery_out ? rec_q + 1 : 0;
         lc_q    <= (switching_out && line_cap_ov_in) ? lc_q + 1 : 0;
      end
   end
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!nrst_in);
   a_gate_in_run: assert property (low_side_gate_pulse_out |-> switching_out)
      else $error("gate pulse outside run state");
   a_first_cut: assert property (switching_out && first_q && low_side_gate_pulse_out
      && hi_q == lim - 8'h01 |=> !low_side_gate_pulse_out && fault_recovery_out
      && fault_cause_out == 4'h6) else $error("first pulse not cut at its limit");
   a_heat_stop: assert property (switching_out && over_temp_in
      |=> !switching_out && supply_cycle_out) else $error("hot device kept switching");
   a_run_clean: assert property ($rose(switching_out)
      |-> !$past(over_temp_in) && !$past(hv_reg_below_14v_in))
      else $error("switching began despite a start fault");
   a_quiet_cycle: assert property (supply_cycle_out
      |-> !low_side_gate_pulse_out && !switching_out) else $error("pulses during restart");
   a_recover_len: assert property ($fell(fault_recovery_out)
      |-> rec_q >= RECOVERY_CYC) else $error("recovery delay too short");
   a_cap_early: assert property ($fell(switching_out) && supply_cycle_out
      && fault_cause_out == 4'h5 |-> lc_q >= LINE_CAP_CYC) else $error("line cap fault early");
   a_cap_late: assert property (switching_out |-> lc_q <= LINE_CAP_CYC + 2)
      else $error("line cap fault late");
   a_recover_kind: assert property ($rose(fault_recovery_out)
      |-> fault_cause_out inside {4'h6, 4'h7}) else $error("wrong cause for recovery");
   a_cycle_kind: assert property ($rose(supply_cycle_out) && !fault_recovery_out
      |-> fault_cause_out inside {[4'h1:4'h5]}) else $error("wrong cause for restart");
   c_recover: cover property ($rose(fault_recovery_out));
   c_run: cover property ($rose(switching_out));
   c_line_cap: cover property ($rose(supply_cycle_out) && fault_cause_out == 4'h5);
endmodule  // pfs_monitor
bind pfs_pin_fault_supervisor pfs_monitor #(.RECOVERY_CYC(RECOVERY_CYC),
   .LINE_CAP_CYC(LINE_CAP_CYC)) pfs_monitor_inst (.sys_clk_in, .nrst_in, .over_temp_in,
   .hv_reg_below_14v_in, .demag_above_th_in, .device_type_sel_in, .line_cap_ov_in,
   .low_side_gate_pulse_out, .supply_cycle_out, .fault_recovery_out, .switching_out,
   .fault_cause_out);
`default_nettype wire

// ===== pfs_stage_model.sv
// pfs_stage_model.sv - power stage: supply thresholds and gate requests.
// assumes the device's cycle and switching levels are registered.
`timescale 1ns/10ps
`default_nettype none
module pfs_stage_model (
   input  wire logic       sys_clk_in,      // system clock
   input  wire logic       nrst_in,         // sync reset, active low
   input  wire logic       pwr_en_in,       // supply may come up
   input  wire logic [7:0] width_in,        // request width in cycles
   input  wire logic       cycle_in,        // device asks for a supply cycle
   input  wire logic       switching_in,    // device switching
   output var  logic       supply_on_out,   // turn-on threshold reached
   output var  logic       supply_off_out,  // turn-off threshold reached
   output var  logic       gate_req_out     // gate request
);
   // ****************************************
   // supply and control loop
   // ****************************************
   logic [6:0] ph_q;
   logic [4:0] fall_q;
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         ph_q           <= 7'h00;
         fall_q         <= 5'h00;
         supply_on_out  <= 1'b0;
         supply_off_out <= 1'b0;
         gate_req_out   <= 1'b0;
      end else begin
         fall_q         <= fall_q + 5'h01;
         ph_q           <= switching_in ? ph_q + 7'h01 : 7'h00;
         supply_on_out  <= pwr_en_in && !cycle_in;
         // supply keeps sagging to turn-off while a restart or recovery runs
         supply_off_out <= cycle_in ? (fall_q == 5'h00) : !pwr_en_in;
         gate_req_out   <= switching_in && ({1'b0, ph_q} < width_in);
      end
   end
endmodule  // pfs_stage_model
`default_nettype wire

// ===== pfs_pin_fault_supervisor_bench.sv
// pfs_pin_fault_supervisor_bench.sv - self-checking bench for the supervisor.
// assumes shortened delay counts; the stage model answers every restart.
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_fault_supervisor_bench;
   // ****************************************
   // stimulus, model and checks
   // ****************************************
   // flags: over-temp, sense, below 14 V, over 15 V, demag pin, zvd pin, line cap
   localparam logic [16:0] CASES [12] = '{{7'h40, 2'b00, 8'h0a}, {7'h04, 2'b00, 8'h0a},
      {7'h02, 2'b00, 8'h0a}, {7'h10, 2'b00, 8'h0a}, {7'h08, 2'b00, 8'h13},
      {7'h08, 2'b10, 8'h27}, {7'h00, 2'b10, 8'h64}, {7'h00, 2'b01, 8'h64},
      {7'h00, 2'b00, 8'h64}, {7'h20, 2'b00, 8'h0a}, {7'h01, 2'b00, 8'h0a},
      {7'h20, 2'b00, 8'h14}};
   logic       sys_clk_in = 1'b0;
   logic       nrst_in = 1'b0;
   logic       pwr_en = 1'b0;
   logic       dev_type = 1'b0;
   logic       above_th = 1'b0;
   logic [6:0] flags = 7'h00;
   logic [7:0] width = 8'h0a;
   wire logic  on_w, off_w, req_w, gate_w, cyc_w, rec_w, sw_w;
   wire logic [3:0] cause_w;
   int         mismatches = 0;
   int         n_compared = 0;
   int         hi_len = 0;
   int         last_len = 0;
   int         sw_seen = 0;
   always #25 sys_clk_in = ~sys_clk_in;
   pfs_pin_fault_supervisor #(.RECOVERY_CYC(25'h064), .LINE_CAP_CYC(25'h032))
      pfs_pin_fault_supervisor_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
      .clk_en_in(1'b1), .supply_on_in(on_w), .supply_off_in(off_w), .gate_req_in(req_w),
      .over_temp_in(flags[6]), .sense_over_ocp_in(flags[5]), .hv_reg_below_14v_in(flags[4]),
      .hv_reg_over_15v_in(flags[3]), .demag_pin_fault_in(flags[2]), .zvd_pin_fault_in(flags[1]),
      .demag_above_th_in(above_th), .device_type_sel_in(dev_type), .line_cap_ov_in(flags[0]),
      .low_side_gate_pulse_out(gate_w), .supply_cycle_out(cyc_w), .fault_recovery_out(rec_w),
      .switching_out(sw_w), .fault_cause_out(cause_w));
   pfs_stage_model pfs_stage_model_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
      .pwr_en_in(pwr_en), .width_in(width), .cycle_in(cyc_w), .switching_in(sw_w),
      .supply_on_out(on_w), .supply_off_out(off_w), .gate_req_out(req_w));
   always @(posedge sys_clk_in) begin
      if (gate_w === 1'b1) hi_len = hi_len + 1;
      else if (hi_len != 0) begin
         last_len = hi_len;
         hi_len = 0;
      end
      if (sw_w === 1'b1) sw_seen = sw_seen + 1;
   end
   function automatic logic [7:0] exp_cause(input logic [6:0] f, input int w, input int lim);
      if (f[6]) return 8'h01;
      if (f[2] || f[1]) return 8'h02;
      if (f[4]) return 8'h03;
      if (w >= lim) return 8'h06;
      if (f[5]) return 8'h07;
      if (f[3]) return 8'h04;
      if (f[0]) return 8'h05;
      return 8'h00;
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // want_sw picks switching_out, else supply_cycle_out
   task automatic wait_up(input bit want_sw);
      for (int i = 0; i < 4000; i++) begin
         @(posedge sys_clk_in);
         #1;
         if ((want_sw ? sw_w : cyc_w) === 1'b1) return;
      end
      check("wait", 8'h00, 8'h01);
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge sys_clk_in);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      logic [7:0] ec;
      int lim;
      void'($urandom(32'hc22b_e01a));
      repeat (3) @(posedge sys_clk_in);
      #1 nrst_in = 1'b1;
      for (int k = 0; k < 12; k++) begin
         {flags, dev_type, above_th, width} = CASES[k];
         if (width < 8'h14) {dev_type, above_th} = 2'($urandom);
         lim = (dev_type || above_th) ? 40 : 20;
         ec = exp_cause(flags, int'(width), lim);
         pwr_en = 1'b1;
         sw_seen = 0;
         wait_up(1'b0);
         @(posedge sys_clk_in);
         #1;
         check("cause", {4'h0, cause_w}, ec);
         check("recovery", {7'h00, rec_w}, {7'h00, ec == 8'h06 || ec == 8'h07});
         if (ec == 8'h06) check("first width", 8'(last_len), 8'(lim));
         if (ec < 8'h04) begin
            repeat (600) @(posedge sys_clk_in);
            #1;
            check("held off", 8'(sw_seen), 8'h00);
         end
         flags = 7'h00;
         width = 8'h05 + 8'($urandom % 10);
         wait_up(1'b1);
         check("cause kept", {4'h0, cause_w}, ec);
         pwr_en = 1'b0;
         repeat (3) @(posedge sys_clk_in);
         #1;
      end
      pwr_en = 1'b1;
      wait_up(1'b1);
      repeat (50) @(posedge sys_clk_in);
      #1 flags = 7'h40;
      wait_up(1'b0);
      check("hot in run", {4'h0, cause_w}, 8'h01);
      tally_and_finish();
   end
endmodule  // pfs_pin_fault_supervisor_bench
`default_nettype wire
